/* File: core/mdu_pkg.sv */
// Shared constants and types of the multiply/divide unit
`default_nettype none
package mdu_pkg;

   localparam int DATA_W      = 32;
   localparam int SLICE_W     = 16;
   localparam int PAIR_W      = 64;
   localparam int MCAND_W     = 33;
   localparam int MPLIER_W    = 17;
   localparam int PROD_W      = 50;
   localparam int CNT_W       = 6;

   // Dividend width classes found by the early-in check
   localparam int DIV_W8      = 8;
   localparam int DIV_W16     = 16;
   localparam int DIV_W24     = 24;
   localparam int SKIP_W8     = 23;
   localparam int SKIP_W16    = 15;
   localparam int SKIP_W24    = 7;
   localparam int SKIP_W32    = 0;
   localparam int DIV_ITER    = 32;

   // Latency in pipeline clocks; repeat rate is one less
   localparam int DIV_LAT_W8  = 12;
   localparam int DIV_LAT_W16 = 19;
   localparam int DIV_LAT_W24 = 26;
   localparam int DIV_LAT_W32 = 33;

   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [PAIR_W-1:0] PAIR_ZERO = 64'h0000_0000_0000_0000;
   localparam logic [CNT_W-1:0]  CNT_ZERO  = 6'h00;
   localparam logic [CNT_W-1:0]  CNT_ONE   = 6'h01;

   typedef enum logic [2:0] {
      multiply_to_result_pair,
      multiply_accumulate_add,
      multiply_accumulate_subtract,
      multiply_to_register,
      divide_op,
      read_result_high_word,
      read_result_low_word
   } op_t;

endpackage
`default_nettype wire

/* File: core/booth_array.sv */
// Radix-4 Booth recoded multiplier array, one slice of the second operand per pass
`timescale 1ns/1ps
`default_nettype none
module booth_array #(
   parameter int A_W = 33,
   parameter int B_W = 17
) (
   // Operands, already extended to signed form
   input  wire logic signed [A_W-1:0]     multiplicand,
   input  wire logic signed [B_W-1:0]     multiplier,
   // Signed product of the pass
   output logic signed      [A_W+B_W-1:0] product
);
   localparam int P_W    = A_W + B_W;
   localparam int DIGITS = (B_W + 1) / 2;

   logic signed [P_W-1:0] a_ext;
   logic signed [P_W-1:0] pp;
   logic        [2*DIGITS:0] b_pad;
   logic        [2:0]        digit;

   always_comb begin
      a_ext   = P_W'(multiplicand);
      b_pad   = {multiplier[B_W-1], multiplier, 1'b0};
      product = '0;
      pp      = '0;
      digit   = 3'h0;
      for (int i = 0; i < DIGITS; i++) begin
         digit = b_pad[2*i +: 3];
         unique case (digit)
            3'h1, 3'h2: pp = a_ext;
            3'h3:       pp = a_ext <<< 1;
            3'h4:       pp = -(a_ext <<< 1);
            3'h5, 3'h6: pp = -a_ext;
            default:    pp = '0;
         endcase
         product = product + (pp <<< (2 * i));
      end
   end
endmodule
`default_nettype wire

/* File: core/mul_div_unit.sv */
// Integer multiply/divide unit with its own pipeline and result pair
//
// Overview of operation
// - Products are formed in a Booth recoded array of a 32-bit first operand by a 16-bit slice.
// - The pass count is chosen from the significant width of the second operand alone.
// - A 16x16 or 32x16 product goes through the array exactly once.
// - A 32x32 product goes through the array twice, the second pass on the upper slice.
// - Short multiplies issue every clock, 32x32 multiplies every second clock.
// - A stall is raised so that a 32x32 multiply cannot follow another back to back.
// - Work in progress advances whether or not the integer pipeline is stalled.
// - Products other than register multiplies, quotients and accumulated sums live in the high/low result pair.
// - Division is iterative and yields one quotient bit per clock.
// - Dividends of 8, 16 and 24 significant bits skip 23, 15 and 7 iterations.
// - While a division runs the integer pipeline is stalled up to its last clock, so the next op lands as it completes.
// - Pair multiplies take latency/repeat 1/1 for a short and 2/2 for a long operand.
// - Register multiplies take latency/repeat 2/1 for a short and 3/2 for a long operand.
// - Division takes 12/11, 19/18, 26/25 and 33/32 clocks by dividend width.
`timescale 1ns/1ps
`default_nettype none
module mul_div_unit (
   // Clock, reset, clock enable
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                ce,
   // Issue from the integer pipeline
   input  wire logic                issue_valid,
   input  wire mdu_pkg::op_t        issue_op,
   input  wire logic                issue_signed,
   input  wire logic [31:0]         first_source_operand,
   input  wire logic [31:0]         second_source_operand,
   // Interlock back to the integer pipeline
   output logic                     stall,
   // Result pair
   output logic [31:0]              result_high_word,
   output logic [31:0]              result_low_word,
   // Register-writing multiply result
   output logic                     gpr_valid,
   output logic [31:0]              gpr_data,
   // Result pair read
   output logic                     read_valid,
   output logic [31:0]              read_data
);
   typedef enum logic [1:0] {st_idle, st_mul_high, st_div_run, st_div_wait} state_t;

   function automatic logic fits(input logic [31:0] v, input logic sgn, input int w);
      if (sgn)
         fits = (($signed(v) >>> (w - 1)) == 0) || (($signed(v) >>> (w - 1)) == -1);
      else
         fits = (v >> w) == 0;
   endfunction

   function automatic logic [31:0] magnitude(input logic [31:0] v, input logic sgn);
      magnitude = (sgn && v[31]) ? 32'(-v) : v;
   endfunction

   state_t             state, next_state;
   logic [31:0]        hi, lo, next_hi, next_lo;
   logic [31:0]        sav_a, sav_b, next_sav_a, next_sav_b;
   logic               sav_sgn, next_sav_sgn;
   mdu_pkg::op_t       sav_op, next_sav_op;
   logic [49:0]        sav_lo_prod, next_sav_lo_prod;
   logic [32:0]        rem, next_rem;
   logic [31:0]        dq, next_dq, divisor, next_divisor;
   logic               q_neg, r_neg, next_q_neg, next_r_neg;
   logic [5:0]         iter, lat, next_iter, next_lat;
   logic               next_stall, next_read_valid, next_gpr_valid, gpr_pend, next_gpr_pend;
   logic [31:0]        next_read_data, next_gpr_data, gpr_hold, next_gpr_hold;

   logic               go, is_mul, long_b, done, div_write;
   logic [5:0]         skip;
   logic [32:0]        trial;
   logic [31:0]        q_val, r_val;
   logic [63:0]        base, full, acc;
   mdu_pkg::op_t       cur_op;
   logic signed [32:0] arr_a;
   logic signed [16:0] arr_b;
   logic signed [49:0] arr_p;

   booth_array #(.A_W(mdu_pkg::MCAND_W), .B_W(mdu_pkg::MPLIER_W)) u_array (
      .multiplicand (arr_a),
      .multiplier   (arr_b),
      .product      (arr_p)
   );

   always_comb begin
      go     = issue_valid && !stall;
      is_mul = issue_op inside {mdu_pkg::multiply_to_result_pair,
                                mdu_pkg::multiply_accumulate_add,
                                mdu_pkg::multiply_accumulate_subtract,
                                mdu_pkg::multiply_to_register};
      long_b = !fits(second_source_operand, issue_signed, mdu_pkg::SLICE_W);

      // Array operand select; the first operand width plays no part
      if (state == st_mul_high) begin
         arr_a = {sav_sgn & sav_a[31], sav_a};
         arr_b = {sav_sgn & sav_b[31], sav_b[31:16]};
      end else begin
         arr_a = {issue_signed & first_source_operand[31], first_source_operand};
         arr_b = {issue_signed & !long_b & second_source_operand[15],
                  second_source_operand[15:0]};
      end

      next_state       = state;
      next_hi          = hi;
      next_lo          = lo;
      next_sav_a       = sav_a;
      next_sav_b       = sav_b;
      next_sav_sgn     = sav_sgn;
      next_sav_op      = sav_op;
      next_sav_lo_prod = sav_lo_prod;
      next_rem         = rem;
      next_dq          = dq;
      next_divisor     = divisor;
      next_q_neg       = q_neg;
      next_r_neg       = r_neg;
      next_iter        = iter;
      next_lat         = lat;
      next_read_valid  = 1'b0;
      next_read_data   = read_data;
      next_gpr_pend    = 1'b0;
      next_gpr_hold    = gpr_hold;
      next_gpr_valid   = gpr_pend;
      next_gpr_data    = gpr_pend ? gpr_hold : gpr_data;
      skip             = 6'(mdu_pkg::SKIP_W32);

      // Division keeps stepping regardless of the integer pipeline
      trial = {rem[31:0], dq[31]} - {1'b0, divisor};
      if (state == st_div_run) begin
         if (!trial[32]) begin
            next_rem = trial;
            next_dq  = {dq[30:0], 1'b1};
         end else begin
            next_rem = {rem[31:0], dq[31]};
            next_dq  = {dq[30:0], 1'b0};
         end
         next_iter = iter - mdu_pkg::CNT_ONE;
         if (iter == mdu_pkg::CNT_ONE)
            next_state = st_div_wait;
      end
      if (state inside {st_div_run, st_div_wait})
         next_lat = lat - mdu_pkg::CNT_ONE;
      q_val     = q_neg ? 32'(-next_dq) : next_dq;
      r_val     = r_neg ? 32'(-next_rem[31:0]) : next_rem[31:0];
      div_write = (state inside {st_div_run, st_div_wait}) && (lat == mdu_pkg::CNT_ONE);
      if (div_write) begin
         next_hi    = r_val;
         next_lo    = q_val;
         next_state = st_idle;
      end

      // Accumulation sees a division result landing on the same edge
      base = {next_hi, next_lo};
      done = 1'b0;
      cur_op = issue_op;
      if (state == st_mul_high) begin
         full   = 64'($signed(sav_lo_prod)) + (64'(arr_p) << mdu_pkg::SLICE_W);
         cur_op = sav_op;
         done   = 1'b1;
         next_state = st_idle;
      end else begin
         full = 64'(arr_p);
         if (go && is_mul) begin
            if (long_b) begin
               next_sav_a       = first_source_operand;
               next_sav_b       = second_source_operand;
               next_sav_sgn     = issue_signed;
               next_sav_op      = issue_op;
               next_sav_lo_prod = arr_p;
               next_state       = st_mul_high;
            end else begin
               done = 1'b1;
            end
         end
      end
      unique case (cur_op)
         mdu_pkg::multiply_accumulate_add:      acc = base + full;
         mdu_pkg::multiply_accumulate_subtract: acc = base - full;
         default:                               acc = full;
      endcase
      if (done) begin
         if (cur_op == mdu_pkg::multiply_to_register) begin
            next_gpr_pend = 1'b1;
            next_gpr_hold = full[31:0];
         end else begin
            next_hi = acc[63:32];
            next_lo = acc[31:0];
         end
      end

      // Early-in check on the dividend sign extension
      if (fits(first_source_operand, issue_signed, mdu_pkg::DIV_W8)) begin
         skip     = 6'(mdu_pkg::SKIP_W8);
      end else if (fits(first_source_operand, issue_signed, mdu_pkg::DIV_W16)) begin
         skip     = 6'(mdu_pkg::SKIP_W16);
      end else if (fits(first_source_operand, issue_signed, mdu_pkg::DIV_W24)) begin
         skip     = 6'(mdu_pkg::SKIP_W24);
      end
      if (go && issue_op == mdu_pkg::divide_op) begin
         next_dq      = magnitude(first_source_operand, issue_signed) << skip;
         next_rem     = 33'h0_0000_0000;
         next_divisor = magnitude(second_source_operand, issue_signed);
         next_q_neg   = issue_signed && (first_source_operand[31] ^ second_source_operand[31]);
         next_r_neg   = issue_signed && first_source_operand[31];
         next_iter    = 6'(mdu_pkg::DIV_ITER) - skip;
         unique case (skip)
            6'(mdu_pkg::SKIP_W8):  next_lat = 6'(mdu_pkg::DIV_LAT_W8 - 1);
            6'(mdu_pkg::SKIP_W16): next_lat = 6'(mdu_pkg::DIV_LAT_W16 - 1);
            6'(mdu_pkg::SKIP_W24): next_lat = 6'(mdu_pkg::DIV_LAT_W24 - 1);
            default:               next_lat = 6'(mdu_pkg::DIV_LAT_W32 - 1);
         endcase
         next_state = st_div_run;
      end

      // Reads return what the pair holds after this edge, so nothing stale leaks out
      if (go && issue_op inside {mdu_pkg::read_result_high_word,
                                 mdu_pkg::read_result_low_word}) begin
         next_read_valid = 1'b1;
         next_read_data  = (issue_op == mdu_pkg::read_result_high_word) ? next_hi : next_lo;
      end

      // Stall is registered, so it covers every cycle a new issue would collide
      next_stall = (next_state == st_mul_high) ||
                   ((next_state inside {st_div_run, st_div_wait}) &&
                    (next_lat > mdu_pkg::CNT_ONE));
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state            <= st_idle;
         hi               <= mdu_pkg::WORD_ZERO;
         lo               <= mdu_pkg::WORD_ZERO;
         sav_a            <= mdu_pkg::WORD_ZERO;
         sav_b            <= mdu_pkg::WORD_ZERO;
         sav_sgn          <= 1'b0;
         sav_op           <= mdu_pkg::multiply_to_result_pair;
         sav_lo_prod      <= '0;
         rem              <= '0;
         dq               <= mdu_pkg::WORD_ZERO;
         divisor          <= mdu_pkg::WORD_ZERO;
         q_neg            <= 1'b0;
         r_neg            <= 1'b0;
         iter             <= mdu_pkg::CNT_ZERO;
         lat              <= mdu_pkg::CNT_ZERO;
         stall            <= 1'b0;
         read_valid       <= 1'b0;
         read_data        <= mdu_pkg::WORD_ZERO;
         gpr_pend         <= 1'b0;
         gpr_hold         <= mdu_pkg::WORD_ZERO;
         gpr_valid        <= 1'b0;
         gpr_data         <= mdu_pkg::WORD_ZERO;
      end else if (ce) begin
         state            <= next_state;
         hi               <= next_hi;
         lo               <= next_lo;
         sav_a            <= next_sav_a;
         sav_b            <= next_sav_b;
         sav_sgn          <= next_sav_sgn;
         sav_op           <= next_sav_op;
         sav_lo_prod      <= next_sav_lo_prod;
         rem              <= next_rem;
         dq               <= next_dq;
         divisor          <= next_divisor;
         q_neg            <= next_q_neg;
         r_neg            <= next_r_neg;
         iter             <= next_iter;
         lat              <= next_lat;
         stall            <= next_stall;
         read_valid       <= next_read_valid;
         read_data        <= next_read_data;
         gpr_pend         <= next_gpr_pend;
         gpr_hold         <= next_gpr_hold;
         gpr_valid        <= next_gpr_valid;
         gpr_data         <= next_gpr_data;
      end
   end

   assign result_high_word = hi;
   assign result_low_word  = lo;

   // Reference values for the checks below
   logic [63:0] exp_prod;
   logic        short_b, div8;
   always_comb begin
      exp_prod = issue_signed ?
                 64'($signed(first_source_operand) * $signed(second_source_operand)) :
                 64'(first_source_operand) * 64'(second_source_operand);
      short_b  = fits(second_source_operand, issue_signed, mdu_pkg::SLICE_W);
      div8     = go && issue_op == mdu_pkg::divide_op &&
                 fits(first_source_operand, issue_signed, mdu_pkg::DIV_W8);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !ce);

   sequence s_pair_mul;
      go && issue_op == mdu_pkg::multiply_to_result_pair;
   endsequence
   sequence s_long_mul;
      s_pair_mul ##0 !short_b;
   endsequence

   a_short_mul_product: assert property (s_pair_mul ##0 short_b |=>
      !stall && {result_high_word, result_low_word} == $past(exp_prod))
      else $error("short multiply result wrong or late");
   a_long_mul_two: assert property (s_long_mul |=> stall ##1
      (!stall && {result_high_word, result_low_word} == $past(exp_prod, 2)))
      else $error("long multiply result wrong or late");
   a_long_mul_block: assert property (s_long_mul |=> stall)
      else $error("no interlock after long multiply");
   a_madd_accum: assert property (go && issue_op == mdu_pkg::multiply_accumulate_add &&
      short_b && !div_write |=>
      {result_high_word, result_low_word} == $past({hi, lo}) + $past(exp_prod))
      else $error("accumulate sum wrong");
   a_gpr_mul_lat: assert property (go && issue_op == mdu_pkg::multiply_to_register &&
      short_b && !gpr_pend |=>
      !gpr_valid ##1 (gpr_valid && gpr_data == $past(exp_prod[31:0], 2)))
      else $error("register multiply latency wrong");
   a_div_short_stall: assert property (div8 |=> stall[*8] ##1 stall ##1 stall ##1 !stall)
      else $error("8-bit divide repeat rate wrong");
   a_div_stall_until: assert property ((state == st_div_run) && lat > mdu_pkg::CNT_ONE
      |-> stall)
      else $error("divide running without stall");
   a_read_forward: assert property (go && issue_op == mdu_pkg::read_result_high_word |=>
      read_valid && read_data == result_high_word)
      else $error("pair read not current");
   a_div_iter_count: assert property (div8 |=> iter == 6'(mdu_pkg::DIV_ITER - mdu_pkg::SKIP_W8))
      else $error("early-in skip wrong");
endmodule
`default_nettype wire

/* File: tb/int_pipe_model.sv */
// Integer pipeline model that presents ops to the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module int_pipe_model (
   // Clock and interlock
   input  wire logic          clk,
   input  wire logic          stall,
   // Issue group
   output var  logic          issue_valid,
   output var  mdu_pkg::op_t  issue_op,
   output var  logic          issue_signed,
   output var  logic [31:0]   first_source_operand,
   output var  logic [31:0]   second_source_operand,
   // Edge count at which the last op was taken
   output var  int            taken_at
);
   int cyc = 0;

   initial begin
      issue_valid = 1'b0;
      issue_op = mdu_pkg::multiply_to_result_pair;
      issue_signed = 1'b0;
      first_source_operand = 32'h0000_0000;
      second_source_operand = 32'h0000_0000;
      taken_at = 0;
   end

   always @(posedge clk) cyc <= cyc + 1;

   // Held until an edge sees the interlock low; refused ops are never dropped
   task automatic issue(input mdu_pkg::op_t op, input logic sgn,
                        input logic [31:0] a, input logic [31:0] b);
      @(negedge clk);
      issue_valid = 1'b1;
      issue_op = op;
      issue_signed = sgn;
      first_source_operand = a;
      second_source_operand = b;
      while (stall !== 1'b0)
         @(negedge clk);
      @(posedge clk);
      taken_at = cyc;
   endtask

   // Operands flip when idle so a unit that keeps reading them is caught
   task automatic idle();
      @(negedge clk);
      issue_valid = 1'b0;
      first_source_operand = ~first_source_operand;
      second_source_operand = ~second_source_operand;
   endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) chk(what, 64'(exp), 64'(got));
module tb;
   typedef struct {
      mdu_pkg::op_t op;
      logic         sgn;
      logic [31:0]  a;
      logic [31:0]  b;
      int           lat;
      int           stl;
   } row_t;

   logic          clk;
   logic          nrst;
   logic          ce;
   logic          issue_valid;
   mdu_pkg::op_t  issue_op;
   logic          issue_signed;
   logic [31:0]   first_source_operand;
   logic [31:0]   second_source_operand;
   logic          stall;
   logic [31:0]   result_high_word;
   logic [31:0]   result_low_word;
   logic          gpr_valid;
   logic [31:0]   gpr_data;
   logic          read_valid;
   logic [31:0]   read_data;
   int            taken_at;
   int            t1;
   int            n_errors = 0;
   int            n_tests = 0;
   logic [63:0]   pair_m;
   logic [63:0]   old;
   logic [63:0]   want;
   logic          is_pair;
   logic          is_reg;
   logic          is_read;

   // Inputs, then latency and stall cycles that they should give
   row_t rows [15] = '{
      '{mdu_pkg::multiply_to_result_pair, 1'b1, 32'h0000_1234, 32'hFFFF_8000, 1, 0},
      '{mdu_pkg::multiply_to_result_pair, 1'b0, 32'hFFFF_FFFF, 32'h0000_FFFF, 1, 0},
      '{mdu_pkg::multiply_to_result_pair, 1'b0, 32'hDEAD_0001, 32'h0001_0000, 2, 1},
      '{mdu_pkg::multiply_to_result_pair, 1'b1, 32'hFFFF_FFF0, 32'h0000_8000, 2, 1},
      '{mdu_pkg::multiply_accumulate_add, 1'b1, 32'hFFFF_FFFF, 32'h0000_0003, 1, 0},
      '{mdu_pkg::multiply_accumulate_subtract, 1'b0, 32'h8000_0001, 32'h1234_5678, 2, 1},
      '{mdu_pkg::multiply_to_register, 1'b0, 32'h0000_0007, 32'h0000_0009, 2, 0},
      '{mdu_pkg::multiply_to_register, 1'b0, 32'h0001_0001, 32'h0001_0001, 3, 1},
      '{mdu_pkg::read_result_high_word, 1'b0, 32'h0000_0000, 32'h0000_0000, 1, 0},
      '{mdu_pkg::read_result_low_word, 1'b0, 32'h0000_0000, 32'h0000_0000, 1, 0},
      '{mdu_pkg::divide_op, 1'b1, 32'hFFFF_FF9C, 32'h0000_0007, 12, 10},
      '{mdu_pkg::divide_op, 1'b0, 32'h0000_FFFF, 32'h0000_000A, 19, 17},
      '{mdu_pkg::divide_op, 1'b1, 32'hFFC0_0000, 32'hFFFF_FFFD, 26, 24},
      '{mdu_pkg::divide_op, 1'b0, 32'h8000_0000, 32'h0000_0003, 33, 31},
      '{mdu_pkg::read_result_low_word, 1'b0, 32'h0000_0000, 32'h0000_0000, 1, 0}
   };

   int_pipe_model pipe (
      .clk                   (clk),
      .stall                 (stall),
      .issue_valid           (issue_valid),
      .issue_op              (issue_op),
      .issue_signed          (issue_signed),
      .first_source_operand  (first_source_operand),
      .second_source_operand (second_source_operand),
      .taken_at              (taken_at)
   );

   mul_div_unit dut (
      .clk                   (clk),
      .nrst                  (nrst),
      .ce                    (ce),
      .issue_valid           (issue_valid),
      .issue_op              (issue_op),
      .issue_signed          (issue_signed),
      .first_source_operand  (first_source_operand),
      .second_source_operand (second_source_operand),
      .stall                 (stall),
      .result_high_word      (result_high_word),
      .result_low_word       (result_low_word),
      .gpr_valid             (gpr_valid),
      .gpr_data              (gpr_data),
      .read_valid            (read_valid),
      .read_data             (read_data)
   );

   // Reference result: new pair, or register/read word in the low half
   function automatic logic [63:0] ref_val(input mdu_pkg::op_t op, input logic s,
         input logic [31:0] a, input logic [31:0] b, input logic [63:0] p);
      logic [63:0] ea;
      logic [63:0] eb;
      logic [63:0] pr;
      ea = s ? {{32{a[31]}}, a} : {32'h0000_0000, a};
      eb = s ? {{32{b[31]}}, b} : {32'h0000_0000, b};
      pr = ea * eb;
      case (op)
         mdu_pkg::multiply_accumulate_add: return p + pr;
         mdu_pkg::multiply_accumulate_subtract: return p - pr;
         mdu_pkg::read_result_high_word: return {32'h0000_0000, p[63:32]};
         mdu_pkg::read_result_low_word: return {32'h0000_0000, p[31:0]};
         mdu_pkg::divide_op: begin
            if (s)
               return {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))};
            return {a % b, a / b};
         end
         default: return pr;
      endcase
   endfunction

   task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wrap_up();
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Whole run is well under 1000 cycles
   initial begin
      #20000;
      n_errors++;
      wrap_up();
   end

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      pair_m = 64'h0000_0000_0000_0000;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      `CHK("reset_out", 0, {result_high_word, result_low_word})
      `CHK("reset_flags", 0, {stall, gpr_valid, read_valid})
      for (int i = 0; i < 15; i++) begin
         old = pair_m;
         want = ref_val(rows[i].op, rows[i].sgn, rows[i].a, rows[i].b, pair_m);
         is_reg = (rows[i].op == mdu_pkg::multiply_to_register);
         is_read = rows[i].op inside {mdu_pkg::read_result_high_word,
                                      mdu_pkg::read_result_low_word};
         is_pair = !is_reg && !is_read;
         pipe.issue(rows[i].op, rows[i].sgn, rows[i].a, rows[i].b);
         for (int k = 1; k <= rows[i].lat; k++) begin
            if (k == 1)
               pipe.idle();
            else
               @(negedge clk);
            `CHK("stall", k <= rows[i].stl, stall)
            `CHK("pair", (is_pair && k == rows[i].lat) ? want : old, {result_high_word, result_low_word})
            `CHK("gpr_valid", is_reg && k == rows[i].lat, gpr_valid)
            `CHK("read_valid", is_read && k == rows[i].lat, read_valid)
            if (is_reg && k == rows[i].lat)
               `CHK("gpr_data", want[31:0], gpr_data)
            if (is_read && k == rows[i].lat)
               `CHK("read_data", want[31:0], read_data)
         end
         if (is_pair)
            pair_m = want;
      end
      // Back-to-back accumulates, one per clock
      want = ref_val(mdu_pkg::multiply_accumulate_add, 1'b1, 32'hFFFF_FFFE, 32'h0000_0005, pair_m);
      want = ref_val(mdu_pkg::multiply_accumulate_add, 1'b1, 32'h0000_1000, 32'hFFFF_FFFF, want);
      pipe.issue(mdu_pkg::multiply_accumulate_add, 1'b1, 32'hFFFF_FFFE, 32'h0000_0005);
      t1 = taken_at;
      pipe.issue(mdu_pkg::multiply_accumulate_add, 1'b1, 32'h0000_1000, 32'hFFFF_FFFF);
      `CHK("short_gap", 1, taken_at - t1)
      pipe.idle();
      `CHK("short_stall", 0, stall)
      @(negedge clk);
      `CHK("acc_pair", want, {result_high_word, result_low_word})
      pair_m = want;
      // Clock enable low freezes the unit, so an op presented then never lands
      ce = 1'b0;
      pipe.issue(mdu_pkg::multiply_to_result_pair, 1'b0, 32'h0000_0002, 32'h0000_0003);
      pipe.idle();
      `CHK("ce_freeze", pair_m, {result_high_word, result_low_word})
      ce = 1'b1;
      // Long multiply straight after a long multiply is interlocked
      pipe.issue(mdu_pkg::multiply_to_result_pair, 1'b0, 32'h0000_0003, 32'h0002_0001);
      t1 = taken_at;
      pipe.issue(mdu_pkg::multiply_to_result_pair, 1'b0, 32'h0000_0005, 32'h0003_0000);
      `CHK("long_gap", 2, taken_at - t1)
      pipe.idle();
      `CHK("long_stall", 1, stall)
      @(negedge clk);
      want = ref_val(mdu_pkg::multiply_to_result_pair, 1'b0, 32'h0000_0005, 32'h0003_0000, pair_m);
      `CHK("long_pair", want, {result_high_word, result_low_word})
      // Read during a divide waits, then sees the fresh quotient
      want = ref_val(mdu_pkg::divide_op, 1'b0, 32'h0000_00C8, 32'h0000_0009, want);
      pipe.issue(mdu_pkg::divide_op, 1'b0, 32'h0000_00C8, 32'h0000_0009);
      t1 = taken_at;
      pipe.issue(mdu_pkg::read_result_low_word, 1'b0, 32'h0000_0000, 32'h0000_0000);
      `CHK("div_gap", 11, taken_at - t1)
      pipe.idle();
      `CHK("read_valid_fwd", 1, read_valid)
      `CHK("read_fwd", want[31:0], read_data)
      // Reset in mid divide drops the interlock and clears the pair
      pipe.issue(mdu_pkg::divide_op, 1'b0, 32'h8000_0000, 32'h0000_0007);
      pipe.idle();
      repeat (3) @(negedge clk);
      nrst = 1'b0;
      #1;
      `CHK("rst_stall", 0, stall)
      `CHK("rst_pair", 0, {result_high_word, result_low_word})
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      pipe.issue(mdu_pkg::multiply_to_result_pair, 1'b0, 32'h0000_0002, 32'h0000_0003);
      pipe.idle();
      `CHK("post_rst", 64'h0000_0000_0000_0006, {result_high_word, result_low_word})
      wrap_up();
   end
endmodule
`undef CHK
`default_nettype wire
